// File: hw/wdt_power_top.sv
// Watchdog and power control registers behind an AHB-Lite slave
//
// Function
// - Watchdog is a divider chain from system clock with selectable tap.
// - Enabled watchdog time-out causes a full system reset.
// - Any reset leaves the watchdog disabled.
// - Any reset clears the 14-bit timer and prescaler.
// - Watchdog control at 8FH: enable, restart, run-in-sleep, divider select.
// - Enable bit starts counting; clearing it stops time-outs.
// - Writing restart clears timer and prescaler; bit self-clears.
// - Timer, prescaler and restart bit are zero by next machine cycle.
// - Run-in-sleep lets watchdog run in idle; defaults clear.
// - Divider select gives ratio two to the (code plus one).
// - Time-out is oscillator period times 2^14 times ratio times 12.
// - Cold-boot flag set on power-on reset, software clearable.
// - User flags are plain read/write storage.
// - Writing power-down request enters power-down mode.
// - Writing sleep request enters idle mode.
// - Input clock is halved before internal use.
// - Idle gates the core clock; any interrupt or reset ends it.
// - Power-down stops all clocks; only reset ends it.
// - Reset clears power control except the cold-boot flag.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module wdt_power_top (
    // Clock and reset
    input  wire logic                       I_CLOCK,
    input  wire logic                       I_RST_N,
    input  wire logic                       I_POR_N,
    // AHB-Lite slave
    input  wire logic                       I_HSEL,
    input  wire logic [wdt_pkg::ADDR_W-1:0] I_HADDR,
    input  wire logic [1:0]                 I_HTRANS,
    input  wire logic                       I_HWRITE,
    input  wire logic [2:0]                 I_HSIZE,
    input  wire logic [31:0]                I_HWDATA,
    input  wire logic                       I_HREADY,
    output logic [31:0]                     O_HRDATA,
    output logic                            O_HREADYOUT,
    output logic                            O_HRESP,
    // System
    input  wire logic                       I_IRQ,
    output logic                            O_SYS_RST,
    output logic                            O_CPU_CLK_EN,
    output logic                            O_PERIPH_CLK_EN,
    output logic                            O_OSC_EN,
    output logic                            O_HALF_CLK,
    output logic                            O_MC_TICK
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic                    cold_reg;
    logic                    cold_next;
    logic [7:0]              pc_reg;
    logic [7:0]              pc_next;
    logic [7:0]              wdc_reg;
    logic [7:0]              wdc_next;
    logic                    restart_pend_reg;
    logic                    restart_pend_next;
    logic                    wr_pend_reg;
    logic                    wr_pend_next;
    logic [ADDR_W-1:0]       wr_addr_reg;
    logic [ADDR_W-1:0]       wr_addr_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    pwr_state_t              pwr_reg;
    pwr_state_t              pwr_next;
    logic [3:0]              rst_cnt_reg;
    logic [3:0]              rst_cnt_next;
    logic                    sys_rst_reg;
    logic                    sys_rst_next;
    logic                    cpu_en_reg;
    logic                    cpu_en_next;
    logic                    per_en_reg;
    logic                    per_en_next;
    logic                    osc_en_reg;
    logic                    osc_en_next;
    logic                    por_seen_reg;
    logic                    cold_in;

    logic                    half;
    logic                    tick;
    logic                    wdt_timeout;
    logic [TIMER_W-1:0]      wdt_timer;
    logic                    wdt_adv;
    logic                    wdt_clear;
    logic                    addr_ok;
    logic                    wr_go;
    logic [7:0]              wbyte;
    logic [1:0]              wr_hit;

    // One-hot select: bit 0 power control, bit 1 watchdog control
    function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] a);
        return {a == WDC_ADDR, a == PWRCTL_ADDR};
    endfunction : reg_hit

    function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] pc,
                                            input logic [7:0] wd);
        logic [1:0] hit;
        hit = reg_hit(a);
        if (hit[0])
            return pc;
        else if (hit[1])
            return wd;
        else
            return 8'h00;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////
    // Clock halver and machine-cycle tick; stopped in power-down
    mc_tick u_tick (
        .i_clk   (I_CLOCK),
        .i_rst_n (I_RST_N),
        .i_run   (pwr_reg != PWR_DOWN),
        .o_half  (half),
        .o_tick  (tick)
    );

    assign wdt_clear = restart_pend_reg;
    assign wdt_adv   = tick && wdc_reg[WDC_EN_BIT]
                       && (pwr_reg == PWR_RUN || (pwr_reg == PWR_IDLE && wdc_reg[WDC_IDLE_RUN_BIT]));

    wdt_chain u_chain (
        .i_clk     (I_CLOCK),
        .i_rst_n   (I_RST_N),
        .i_adv     (wdt_adv),
        .i_clear   (wdt_clear),
        .i_sel     (wdc_reg[WDC_SEL_LSB +: WDC_SEL_W]),
        .o_timeout (wdt_timeout),
        .o_timer   (wdt_timer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign addr_ok = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ || I_HTRANS == HTRANS_SEQ);
    assign wr_go   = wr_pend_reg;
    assign wbyte   = I_HWDATA[7:0];
    assign wr_hit  = reg_hit(wr_addr_reg);

    always_comb begin
        wr_pend_next = addr_ok && I_HWRITE;
        wr_addr_next = (addr_ok && I_HWRITE) ? I_HADDR : wr_addr_reg;
        rdata_next   = rdata_reg;
        if (addr_ok && !I_HWRITE)
            rdata_next = {24'h000000, reg_read(I_HADDR, pc_reg, wdc_reg)};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates
    always_comb begin
        pc_next           = pc_reg;
        wdc_next          = wdc_reg;
        cold_next         = cold_reg;
        restart_pend_next = 1'b0;
        // Restart bit clears itself once the chain is cleared
        if (restart_pend_reg)
            wdc_next[WDC_RESTART_BIT] = 1'b0;
        // Wake from idle on interrupt
        if (pwr_reg == PWR_IDLE && I_IRQ)
            pc_next[PC_IDLE_BIT] = 1'b0;
        if (wr_go && wr_hit[0]) begin
            cold_next             = wbyte[PC_COLD_BIT];
            pc_next[PC_UF1_BIT]   = wbyte[PC_UF1_BIT];
            pc_next[PC_UF0_BIT]   = wbyte[PC_UF0_BIT];
            pc_next[PC_PDOWN_BIT] = wbyte[PC_PDOWN_BIT];
            pc_next[PC_IDLE_BIT]  = wbyte[PC_IDLE_BIT];
        end
        if (wr_go && wr_hit[1]) begin
            wdc_next[WDC_EN_BIT]                     = wbyte[WDC_EN_BIT];
            wdc_next[WDC_RESTART_BIT]                = wbyte[WDC_RESTART_BIT];
            wdc_next[WDC_IDLE_RUN_BIT]               = wbyte[WDC_IDLE_RUN_BIT];
            wdc_next[WDC_SEL_LSB +: WDC_SEL_W]       = wbyte[WDC_SEL_LSB +: WDC_SEL_W];
            restart_pend_next                        = wbyte[WDC_RESTART_BIT];
        end
        pc_next[PC_COLD_BIT] = cold_next;
        pc_next[7:5]         = 3'h0;
        wdc_next[4:3]        = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power mode and clock enables
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_RUN: begin
                if (pc_next[PC_PDOWN_BIT])
                    pwr_next = PWR_DOWN;
                else if (pc_next[PC_IDLE_BIT])
                    pwr_next = PWR_IDLE;
            end
            PWR_IDLE: begin
                if (pc_next[PC_PDOWN_BIT])
                    pwr_next = PWR_DOWN;
                else if (!pc_next[PC_IDLE_BIT])
                    pwr_next = PWR_RUN;
            end
            PWR_DOWN: pwr_next = PWR_DOWN;
            default:  pwr_next = PWR_RUN;
        endcase
        cpu_en_next = (pwr_next == PWR_RUN);
        per_en_next = (pwr_next != PWR_DOWN);
        osc_en_next = (pwr_next != PWR_DOWN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog reset pulse; one extra tick covers a partial first machine cycle
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        sys_rst_next = 1'b0;
        if (wdt_timeout && wdc_reg[WDC_EN_BIT])
            rst_cnt_next = RST_HOLD_MC + 4'h1;
        else if (rst_cnt_reg != 4'h0 && tick)
            rst_cnt_next = rst_cnt_reg - 4'h1;
        if (rst_cnt_next != 4'h0)
            sys_rst_next = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cold-boot flag: caught on power-on reset, survives other resets
    always_comb begin
        cold_in = por_seen_reg ? 1'b1 : cold_next;
    end

    always_ff @(posedge I_CLOCK or negedge I_POR_N) begin
        if (!I_POR_N) begin
            por_seen_reg <= 1'b1;
            cold_reg     <= 1'b1;
        end else begin
            por_seen_reg <= 1'b0;
            cold_reg     <= cold_in;
        end
    end

    // Register file
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pc_reg           <= PC_RESET_VAL;
            wdc_reg          <= WDC_RESET_VAL;
            restart_pend_reg <= 1'b0;
        end else begin
            pc_reg           <= pc_next;
            wdc_reg          <= wdc_next;
            restart_pend_reg <= restart_pend_next;
        end
    end

    // Bus state
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            rdata_reg   <= 32'h00000000;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Power mode and clock enables
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pwr_reg    <= PWR_RUN;
            cpu_en_reg <= 1'b1;
            per_en_reg <= 1'b1;
            osc_en_reg <= 1'b1;
        end else begin
            pwr_reg    <= pwr_next;
            cpu_en_reg <= cpu_en_next;
            per_en_reg <= per_en_next;
            osc_en_reg <= osc_en_next;
        end
    end

    // Watchdog reset pulse
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_cnt_reg <= 4'h0;
            sys_rst_reg <= 1'b0;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            sys_rst_reg <= sys_rst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign O_HRDATA        = rdata_reg;
    assign O_HREADYOUT     = 1'b1;
    assign O_HRESP         = 1'b0;
    assign O_SYS_RST       = sys_rst_reg;
    assign O_CPU_CLK_EN    = cpu_en_reg;
    assign O_PERIPH_CLK_EN = per_en_reg;
    assign O_OSC_EN        = osc_en_reg;
    assign O_HALF_CLK      = half;
    assign O_MC_TICK       = tick;
endmodule : wdt_power_top

// File: inc/wdt_pkg.sv
// Constants and types shared by the watchdog and power-control block
package wdt_pkg;
    // Register byte addresses: register index times four
    localparam logic [7:0]  PWRCTL_INDEX      = 8'h87;
    localparam logic [7:0]  WDC_INDEX         = 8'h8f;
    localparam logic [9:0]  PWRCTL_ADDR       = {PWRCTL_INDEX, 2'b00};
    localparam logic [9:0]  WDC_ADDR          = {WDC_INDEX, 2'b00};
    localparam int          ADDR_W            = 10;
    // Watchdog control fields
    localparam int          WDC_EN_BIT        = 7;
    localparam int          WDC_RESTART_BIT   = 6;
    localparam int          WDC_IDLE_RUN_BIT  = 5;
    localparam int          WDC_SEL_LSB       = 0;
    localparam int          WDC_SEL_W         = 3;
    // Power control fields
    localparam int          PC_COLD_BIT       = 4;
    localparam int          PC_UF1_BIT        = 3;
    localparam int          PC_UF0_BIT        = 2;
    localparam int          PC_PDOWN_BIT      = 1;
    localparam int          PC_IDLE_BIT       = 0;
    localparam logic [7:0]  PC_RESET_VAL      = 8'h00;
    localparam logic [7:0]  WDC_RESET_VAL     = 8'h00;
    // Divider chain
    localparam int          TIMER_W           = 14;
    localparam int          PRESC_W           = 8;
    localparam logic [3:0]  OSC_PER_MC        = 4'hc;
    localparam logic [3:0]  CLKDIV_PER_MC     = 4'h6;
    localparam logic [3:0]  RST_HOLD_MC       = 4'h2;
    // AHB transfer types
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ        = 2'h3;

    typedef enum logic [2:0] {
        PWR_RUN   = 3'b001,
        PWR_IDLE  = 3'b010,
        PWR_DOWN  = 3'b100
    } pwr_state_t;
endpackage : wdt_pkg

// File: hw/mc_tick.sv
// Clock halver and machine-cycle tick generator
`timescale 1ns/1ps
module mc_tick (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Gating
    input  wire logic       i_run,
    // Outputs
    output logic            o_half,
    output logic            o_tick
);
    import wdt_pkg::*;

    logic       half_reg;
    logic       half_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;

    always_comb begin
        half_next = i_run ? ~half_reg : half_reg;
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (i_run && half_reg) begin
            if (cnt_reg == CLKDIV_PER_MC - 4'h1) begin
                cnt_next  = 4'h0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_reg <= 1'b0;
            cnt_reg  <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            half_reg <= half_next;
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign o_half = half_reg;
    assign o_tick = tick_reg;
endmodule : mc_tick

// File: hw/wdt_chain.sv
// Watchdog prescaler and 14-bit timer with selectable tap
`timescale 1ns/1ps
module wdt_chain (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_adv,
    input  wire logic       i_clear,
    input  wire logic [2:0] i_sel,
    // Status
    output logic            o_timeout,
    output logic [13:0]     o_timer
);
    import wdt_pkg::*;

    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    logic               to_reg;
    logic               to_next;
    logic [PRESC_W-1:0] tap_mask;

    // Ratio 2^(sel+1): terminal count mask
    function automatic logic [PRESC_W-1:0] sel_mask(input logic [2:0] sel);
        logic [PRESC_W:0] m;
        m = ({{PRESC_W{1'b0}}, 1'b1} << ({1'b0, sel} + 4'h1)) - 9'h1;
        return m[PRESC_W-1:0];
    endfunction : sel_mask

    always_comb begin
        tap_mask   = sel_mask(i_sel);
        presc_next = presc_reg;
        timer_next = timer_reg;
        to_next    = 1'b0;
        if (i_clear) begin
            presc_next = '0;
            timer_next = '0;
        end else if (i_adv) begin
            if ((presc_reg & tap_mask) == tap_mask) begin
                presc_next = '0;
                timer_next = timer_reg + 14'h1;
                to_next    = &timer_reg;
            end else begin
                presc_next = presc_reg + 8'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc_reg <= '0;
            timer_reg <= '0;
            to_reg    <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            timer_reg <= timer_next;
            to_reg    <= to_next;
        end
    end

    assign o_timeout = to_reg;
    assign o_timer   = timer_reg;
endmodule : wdt_chain

// File: dv/wdt_power_monitor.sv
// Port checker for the watchdog and power-control block
`timescale 1ns/1ps
module wdt_power_monitor (
    // Clock and reset
    input wire logic                       I_CLOCK,
    input wire logic                       I_RST_N,
    // Bus
    input wire logic                       I_HSEL,
    input wire logic [wdt_pkg::ADDR_W-1:0] I_HADDR,
    input wire logic [1:0]                 I_HTRANS,
    input wire logic                       I_HWRITE,
    input wire logic                       I_HREADY,
    input wire logic [31:0]                O_HRDATA,
    // System
    input wire logic                       I_IRQ,
    input wire logic                       O_SYS_RST,
    input wire logic                       O_CPU_CLK_EN,
    input wire logic                       O_PERIPH_CLK_EN,
    input wire logic                       O_OSC_EN,
    input wire logic                       O_HALF_CLK,
    input wire logic                       O_MC_TICK
);
    import wdt_pkg::*;
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);

    logic rd_miss;
    assign rd_miss = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_HADDR != PWRCTL_ADDR && I_HADDR != WDC_ADDR;

    ////////////////////////////////////////////////////////////////////////////
    a_run_clocks: assert property (O_CPU_CLK_EN |-> O_PERIPH_CLK_EN && O_OSC_EN)
        else $error("core clock enabled without peripheral clock");
    a_half_toggle: assert property (O_OSC_EN && $past(O_OSC_EN) && $past(I_RST_N)
        |-> O_HALF_CLK != $past(O_HALF_CLK))
        else $error("half clock did not toggle");
    a_half_frozen: assert property (!O_OSC_EN && !$past(O_OSC_EN) |-> $stable(O_HALF_CLK))
        else $error("half clock moved in power-down");
    a_tick_period: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N || !O_OSC_EN)
        O_MC_TICK |=> (!O_MC_TICK)[*8] ##1 (!O_MC_TICK)[*3] ##1 O_MC_TICK)
        else $error("machine tick spacing not twelve");
    a_pd_holds: assert property (!O_OSC_EN |=> !O_OSC_EN)
        else $error("power-down left without reset");
    a_pd_gates: assert property (!O_OSC_EN |-> !O_PERIPH_CLK_EN && !O_CPU_CLK_EN)
        else $error("clock enabled in power-down");
    a_irq_wakes: assert property (!O_CPU_CLK_EN && O_PERIPH_CLK_EN && I_IRQ |-> ##[1:4] O_CPU_CLK_EN)
        else $error("interrupt did not end idle");
    a_miss_zero: assert property (rd_miss |=> O_HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_byte: assert property (O_HRDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_wdrst_hold: assert property ($rose(O_SYS_RST) |-> O_SYS_RST[*8])
        else $error("watchdog reset too short");

    c_idle: cover property (!O_CPU_CLK_EN && O_PERIPH_CLK_EN);
    c_pdown: cover property (!O_OSC_EN);
    c_miss: cover property (rd_miss);
endmodule : wdt_power_monitor

bind wdt_power_top wdt_power_monitor u_mon (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .I_IRQ(I_IRQ), .O_SYS_RST(O_SYS_RST), .O_CPU_CLK_EN(O_CPU_CLK_EN),
    .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN), .O_OSC_EN(O_OSC_EN), .O_HALF_CLK(O_HALF_CLK),
    .O_MC_TICK(O_MC_TICK)
);

// File: dv/sfr_master.sv
// Processor-side bus master model issuing single register transfers
`timescale 1ns/1ps
module sfr_master (
    // Clock
    input  wire logic                       i_clk,
    // Bus answer
    input  wire logic                       i_hready,
    input  wire logic [31:0]                i_hrdata,
    // Bus request
    output logic                            o_hsel,
    output logic [wdt_pkg::ADDR_W-1:0]      o_haddr,
    output logic [1:0]                      o_htrans,
    output logic                            o_hwrite,
    output logic [2:0]                      o_hsize,
    output logic [31:0]                     o_hwdata
);
    import wdt_pkg::*;
    initial begin
        o_hsel = 1'b0;
        o_haddr = '0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address phase held until ready, then data phase held until ready
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge i_clk);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_htrans <= HTRANS_NONSEQ;
        o_hwrite <= wr;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= {24'h0, d};
        do @(posedge i_clk); while (i_hready !== 1'b1);
        q = i_hrdata;
    endtask : xfer
endmodule : sfr_master

// File: dv/wdt_power_top_tb_top.sv
// Self-checking bench for the watchdog and power-control block
`timescale 1ns/1ps
module wdt_power_top_tb_top;
    import wdt_pkg::*;
    logic              clk, rst_n, por_n, irq;
    logic              hsel, hwrite, hreadyout, hresp, sys_rst, cpu_en, per_en, osc_en, half, tick;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       hwdata, hrdata, q;
    int                n_errors, total_checks, cycles, n;
    logic              h;

    sfr_master u_cpu (.i_clk(clk), .i_hready(hreadyout), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
    wdt_power_top uut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
        .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_IRQ(irq), .O_SYS_RST(sys_rst),
        .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_OSC_EN(osc_en), .O_HALF_CLK(half),
        .O_MC_TICK(tick));

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        por_n = 1'b0;
        irq = 1'b0;
        n_errors = 0;
        total_checks = 0;
        cycles = 0;
    end
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        u_cpu.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        u_cpu.xfer(1'b0, a, 8'h00, q);
        chk(name, {24'h0, exp}, q);
    endtask : rd_chk
    task automatic do_reset(input logic cold);
        rst_n <= 1'b0;
        por_n <= ~cold;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        do_reset(1'b1);
        rd_chk("pc_cold", PWRCTL_ADDR, 8'h10);
        rd_chk("wd_rst", WDC_ADDR, 8'h00);
        chk("run_en", 32'h1, {31'h0, cpu_en & per_en & osc_en});
        chk("bus_ok", 32'h2, {30'h0, hreadyout, hresp});
    endtask : t_reset_vals
    task automatic t_wd_reg();
        wr(WDC_ADDR, 8'hff);
        rd_chk("wd_all", WDC_ADDR, 8'ha7);
        wr(WDC_ADDR, 8'hc0);
        rd_chk("wd_restart", WDC_ADDR, 8'h80);
        chk("no_wd_rst", 32'h0, {31'h0, sys_rst});
        for (int s = 0; s < 8; s++) begin
            wr(WDC_ADDR, 8'(s));
            rd_chk("wd_sel", WDC_ADDR, 8'(s));
        end
        rd_chk("miss", 10'h100, 8'h00);
    endtask : t_wd_reg
    task automatic t_tick();
        n = 0;
        while (tick !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 50);
        chk("tick_gap", 32'd12, n);
    endtask : t_tick
    task automatic t_pc_flags();
        wr(PWRCTL_ADDR, 8'h1c);
        rd_chk("pc_user", PWRCTL_ADDR, 8'h1c);
        wr(PWRCTL_ADDR, 8'h00);
        rd_chk("pc_clear", PWRCTL_ADDR, 8'h00);
        wr(PWRCTL_ADDR, 8'h0c);
        wr(WDC_ADDR, 8'ha5);
        do_reset(1'b0);
        rd_chk("pc_warm", PWRCTL_ADDR, 8'h00);
        rd_chk("wd_warm", WDC_ADDR, 8'h00);
    endtask : t_pc_flags
    task automatic t_idle();
        wr(PWRCTL_ADDR, 8'h01);
        repeat (3) @(posedge clk);
        chk("idle_cpu", 32'h0, {31'h0, cpu_en});
        chk("idle_per", 32'h1, {31'h0, per_en});
        n = 0;
        repeat (24) begin
            @(posedge clk);
            n += int'(tick === 1'b1);
        end
        chk("idle_ticks", 32'd2, n);
        irq <= 1'b1;
        repeat (4) @(posedge clk);
        chk("wake_cpu", 32'h1, {31'h0, cpu_en});
        irq <= 1'b0;
        rd_chk("pc_woke", PWRCTL_ADDR, 8'h00);
    endtask : t_idle
    task automatic t_pdown();
        wr(PWRCTL_ADDR, 8'h12);
        repeat (3) @(posedge clk);
        chk("pd_en", 32'h0, {29'h0, osc_en, per_en, cpu_en});
        h = half;
        repeat (5) @(posedge clk);
        chk("pd_half", {31'h0, h}, {31'h0, half});
        do_reset(1'b0);
        repeat (2) @(posedge clk);
        chk("pd_exit", 32'h7, {29'h0, osc_en, per_en, cpu_en});
        rd_chk("pd_cold", PWRCTL_ADDR, 8'h10);
    endtask : t_pdown

    initial begin
        t_reset_vals();
        t_wd_reg();
        t_tick();
        t_pc_flags();
        t_idle();
        t_pdown();
        give_verdict();
    end
endmodule : wdt_power_top_tb_top
